// ===== design/dit_pkg.sv
package dit_pkg;

	// Clock and scan timing
	localparam int unsigned CLK_PERIOD_PS = 10_000;
	localparam int unsigned SCAN_UNIT_PS = 100_000_000;
	localparam int unsigned SCAN_UNIT_CYC = SCAN_UNIT_PS / CLK_PERIOD_PS;
	localparam logic [10:0] SCAN_SET_MIN = 11'h00a;
	localparam logic [10:0] SCAN_SET_MAX = 11'h7d0;
	localparam logic [10:0] SCAN_SET_RST = 11'h00a;

	// Ramp floor in units of 0.1 s (20 s)
	localparam logic [15:0] RAMP_MIN_DS = 16'h00c8;

	// Two-terminal modes
	localparam logic [1:0] MODE_FWD_REV = 2'h0;
	localparam logic [1:0] MODE_RUN_DIR = 2'h1;
	localparam logic [1:0] MODE_3WIRE = 2'h2;

	// Control source and frequency source codes
	localparam logic [3:0] RUN_SRC_TERMINAL = 4'h1;
	localparam logic [3:0] FREQ_SRC_UPDOWN = 4'h8;

	// Multifunction codes
	localparam logic [3:0] FN_NONE = 4'h0;
	localparam logic [3:0] FN_FAULT = 4'h1;
	localparam logic [3:0] FN_RESET = 4'h2;
	localparam logic [3:0] FN_COAST = 4'h3;
	localparam logic [3:0] FN_UP = 4'h4;
	localparam logic [3:0] FN_DOWN = 4'h5;
	localparam logic [3:0] FN_STAGE0 = 4'h6;
	localparam logic [3:0] FN_STAGE1 = 4'h7;
	localparam logic [3:0] FN_STAGE2 = 4'h8;
	localparam logic [3:0] FN_STAGE3 = 4'h9;
	localparam logic [3:0] FN_JOG = 4'ha;
	localparam logic [3:0] FN_AUTO = 4'hb;
	localparam logic [3:0] FN_PAUSE = 4'hc;
	localparam logic [3:0] FN_PID = 4'hd;
	localparam logic [3:0] FN_ANALOG1 = 4'he;
	localparam logic [3:0] FN_FIELDBUS = 4'hf;
	localparam logic [3:0] FN_MAX_3TO7 = 4'he;

	// Reset values of the input3..input8 functions
	localparam logic [3:0] IN3_FN_RST = 4'h1;
	localparam logic [3:0] IN4_FN_RST = 4'h2;
	localparam logic [3:0] IN5_FN_RST = 4'h6;
	localparam logic [3:0] IN6_FN_RST = 4'h7;
	localparam logic [3:0] IN7_FN_RST = 4'ha;
	localparam logic [3:0] IN8_FN_RST = 4'h3;

	typedef enum logic [2:0] {
		SRC_AUTO,
		SRC_JOG,
		SRC_ANALOG1,
		SRC_STAGE,
		SRC_CONFIG
	} dit_src_t;

endpackage

// ===== design/dit_scan_filter.sv
module dit_scan_filter (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic scan_tick_i,
	input wire logic [7:0] level_i,
	output logic [7:0] level_o
);
	import dit_pkg::*;

	logic [7:0] sample_reg;
	logic [7:0] stable_reg;

	// A level is taken only when two scans in a row agree
	for (genvar i = 0; i < 8; i++) begin : g_bit
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				sample_reg[i] <= 1'b0;
				stable_reg[i] <= 1'b0;
			end else if (scan_tick_i) begin
				sample_reg[i] <= level_i[i];
				if (sample_reg[i] == level_i[i]) begin
					stable_reg[i] <= level_i[i];
				end
			end
		end
	end

	assign level_o = stable_reg;

	AST_FILTER_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!scan_tick_i |=> $stable(stable_reg))
		else $error("filtered level moved without a scan");
endmodule

// ===== design/dit_decoder.sv
module dit_decoder #(
	parameter int unsigned SCAN_UNIT_CYCLES = dit_pkg::SCAN_UNIT_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] terminals_i,
	input wire logic [10:0] input_scan_period_i,
	input wire logic [1:0] two_terminal_mode_i,
	input wire logic [3:0] input3_function_i,
	input wire logic [3:0] input4_function_i,
	input wire logic [3:0] input5_function_i,
	input wire logic [3:0] input6_function_i,
	input wire logic [3:0] input7_function_i,
	input wire logic [3:0] input8_function_i,
	input wire logic [3:0] run_control_source_i,
	input wire logic [3:0] frequency_command_source_i,
	input wire logic [15:0] accel_time_i,
	input wire logic [15:0] decel_time_i,
	output logic [7:0] terminals_o,
	output logic run_o,
	output logic reverse_o,
	output logic fault_o,
	output logic coast_o,
	output logic output_off_o,
	output logic speed_up_o,
	output logic speed_down_o,
	output logic [15:0] ramp_time_o,
	output logic [3:0] stage_sel_o,
	output dit_pkg::dit_src_t speed_source_o,
	output logic auto_run_o,
	output logic auto_pause_o,
	output logic auto_restart_o,
	output logic pid_enable_o,
	output logic analog1_forced_o,
	output logic fieldbus_enable_o
);
	import dit_pkg::*;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	// True when any enabled multifunction input that is active carries the given code
	function automatic logic fn_hit(input logic [5:0][3:0] codes, input logic [5:0] en,
			input logic [5:0] lvl, input logic [3:0] code);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 6; k++) begin
			if (en[k] && lvl[k] && codes[k] == code && code != FN_NONE) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic [7:0] filt;
	logic [13:0] unit_cnt_reg;
	logic [10:0] period_cnt_reg;
	logic scan_tick_reg;
	logic [10:0] scan_set;
	logic [5:0][3:0] codes;
	logic [5:0] fn_en;
	logic f_fault, f_reset, f_coast, f_up, f_down, f_jog, f_auto, f_pause;
	logic f_pid, f_ana, f_bus;
	logic [3:0] stage_code;
	logic reset_prev_reg, auto_prev_reg, in1_prev_reg;
	logic wire3_run_reg;
	logic run_next, rev_next;
	dit_src_t src_next;

	// Two-flop synchroniser for the terminal pins
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
		end else begin
			sync1_reg <= terminals_i;
			sync2_reg <= sync1_reg;
		end
	end

	// Setting clamped into its legal range
	always_comb begin
		if (input_scan_period_i < SCAN_SET_MIN) begin
			scan_set = SCAN_SET_MIN;
		end else if (input_scan_period_i > SCAN_SET_MAX) begin
			scan_set = SCAN_SET_MAX;
		end else begin
			scan_set = input_scan_period_i;
		end
	end

	// 0.1 ms unit divider, then a count of units per scan
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			unit_cnt_reg <= 14'h0000;
			period_cnt_reg <= 11'h000;
			scan_tick_reg <= 1'b0;
		end else begin
			scan_tick_reg <= 1'b0;
			if (unit_cnt_reg == 14'(SCAN_UNIT_CYCLES - 1)) begin
				unit_cnt_reg <= 14'h0000;
				if (period_cnt_reg >= scan_set - 11'h001) begin
					period_cnt_reg <= 11'h000;
					scan_tick_reg <= 1'b1;
				end else begin
					period_cnt_reg <= period_cnt_reg + 11'h001;
				end
			end else begin
				unit_cnt_reg <= unit_cnt_reg + 14'h0001;
			end
		end
	end

	dit_scan_filter u_filter (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.scan_tick_i(scan_tick_reg),
		.level_i(sync2_reg),
		.level_o(filt)
	);

	// Function assignment per multifunction input
	always_comb begin
		codes[0] = input3_function_i;
		codes[1] = input4_function_i;
		codes[2] = input5_function_i;
		codes[3] = input6_function_i;
		codes[4] = input7_function_i;
		codes[5] = input8_function_i;
		for (int k = 0; k < 5; k++) begin
			fn_en[k] = codes[k] <= FN_MAX_3TO7;
		end
		fn_en[5] = 1'b1;
		if (two_terminal_mode_i == MODE_3WIRE) begin
			fn_en[0] = 1'b0;
		end
	end

	assign f_fault = fn_hit(codes, fn_en, filt[7:2], FN_FAULT);
	assign f_reset = fn_hit(codes, fn_en, filt[7:2], FN_RESET);
	assign f_coast = fn_hit(codes, fn_en, filt[7:2], FN_COAST);
	assign f_up = fn_hit(codes, fn_en, filt[7:2], FN_UP);
	assign f_down = fn_hit(codes, fn_en, filt[7:2], FN_DOWN);
	assign f_jog = fn_hit(codes, fn_en, filt[7:2], FN_JOG);
	assign f_auto = fn_hit(codes, fn_en, filt[7:2], FN_AUTO);
	assign f_pause = fn_hit(codes, fn_en, filt[7:2], FN_PAUSE);
	assign f_pid = fn_hit(codes, fn_en, filt[7:2], FN_PID);
	assign f_ana = fn_hit(codes, fn_en, filt[7:2], FN_ANALOG1);
	assign f_bus = fn_hit(codes, fn_en, filt[7:2], FN_FIELDBUS);
	assign stage_code = {fn_hit(codes, fn_en, filt[7:2], FN_STAGE3),
		fn_hit(codes, fn_en, filt[7:2], FN_STAGE2),
		fn_hit(codes, fn_en, filt[7:2], FN_STAGE1),
		fn_hit(codes, fn_en, filt[7:2], FN_STAGE0)};

	// Edge history
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reset_prev_reg <= 1'b0;
			auto_prev_reg <= 1'b0;
			in1_prev_reg <= 1'b0;
		end else begin
			reset_prev_reg <= f_reset;
			auto_prev_reg <= f_auto;
			in1_prev_reg <= filt[0];
		end
	end

	// Latched fault: a new trip wins over a reset in the same cycle
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fault_o <= 1'b0;
		end else if (f_fault) begin
			fault_o <= 1'b1;
		end else if (f_reset && !reset_prev_reg) begin
			fault_o <= 1'b0;
		end
	end

	// Three-wire latch: start on a closing of input one, stop on input two open
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wire3_run_reg <= 1'b0;
		end else if (two_terminal_mode_i != MODE_3WIRE || !filt[1]) begin
			wire3_run_reg <= 1'b0;
		end else if (filt[0] && !in1_prev_reg) begin
			wire3_run_reg <= 1'b1;
		end
	end

	// Run and direction decode
	always_comb begin
		run_next = 1'b0;
		rev_next = 1'b0;
		unique case (two_terminal_mode_i)
			MODE_FWD_REV: begin
				run_next = filt[0] ^ filt[1];
				rev_next = filt[1] && !filt[0];
			end
			MODE_RUN_DIR: begin
				run_next = filt[0];
				rev_next = filt[1];
			end
			MODE_3WIRE: begin
				run_next = wire3_run_reg;
				rev_next = filt[2];
			end
			default: begin
				run_next = 1'b0;
				rev_next = 1'b0;
			end
		endcase
		if (run_control_source_i != RUN_SRC_TERMINAL || fault_o || f_coast) begin
			run_next = 1'b0;
		end
	end

	// Speed source priority
	always_comb begin
		if (f_auto) begin
			src_next = SRC_AUTO;
		end else if (f_jog) begin
			src_next = SRC_JOG;
		end else if (f_ana) begin
			src_next = SRC_ANALOG1;
		end else if (stage_code != 4'h0) begin
			src_next = SRC_STAGE;
		end else begin
			src_next = SRC_CONFIG;
		end
	end

	// Run, stop and output cut-off
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_o <= 1'b0;
			reverse_o <= 1'b0;
			coast_o <= 1'b0;
			output_off_o <= 1'b1;
			terminals_o <= 8'h00;
		end else begin
			run_o <= run_next;
			reverse_o <= rev_next;
			coast_o <= f_coast;
			output_off_o <= f_coast || f_fault || fault_o;
			terminals_o <= filt;
		end
	end

	// Master speed up/down with a ramp floor
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			speed_up_o <= 1'b0;
			speed_down_o <= 1'b0;
			ramp_time_o <= RAMP_MIN_DS;
		end else begin
			speed_up_o <= f_up && !f_down && frequency_command_source_i == FREQ_SRC_UPDOWN;
			speed_down_o <= f_down && !f_up && frequency_command_source_i == FREQ_SRC_UPDOWN;
			if (f_down && !f_up) begin
				ramp_time_o <= (decel_time_i < RAMP_MIN_DS) ? RAMP_MIN_DS : decel_time_i;
			end else begin
				ramp_time_o <= (accel_time_i < RAMP_MIN_DS) ? RAMP_MIN_DS : accel_time_i;
			end
		end
	end

	// Speed selection, auto sequence and auxiliary enables
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			speed_source_o <= SRC_CONFIG;
			stage_sel_o <= 4'h0;
			auto_run_o <= 1'b0;
			auto_pause_o <= 1'b0;
			auto_restart_o <= 1'b0;
			pid_enable_o <= 1'b0;
			analog1_forced_o <= 1'b0;
			fieldbus_enable_o <= 1'b0;
		end else begin
			speed_source_o <= src_next;
			stage_sel_o <= stage_code;
			auto_run_o <= f_auto;
			auto_pause_o <= f_auto && f_pause;
			auto_restart_o <= f_auto && !auto_prev_reg;
			pid_enable_o <= f_pid;
			analog1_forced_o <= f_ana;
			fieldbus_enable_o <= f_bus;
		end
	end

	AST_FAULT_TRIP: assert property (f_fault |=> fault_o && output_off_o)
		else $error("external fault did not trip");
	AST_FAULT_CLEAR: assert property (f_reset && !reset_prev_reg && !f_fault |=> !fault_o)
		else $error("reset did not clear fault");
	AST_COAST_OFF: assert property (f_coast |=> coast_o && output_off_o && !run_o)
		else $error("coast did not cut output");
	AST_MODE0_FWD: assert property (two_terminal_mode_i == MODE_FWD_REV && filt[0]
			&& !filt[1] && run_control_source_i == RUN_SRC_TERMINAL && !fault_o && !f_coast
			|=> run_o && !reverse_o)
		else $error("mode 0 forward run wrong");
	AST_MODE1_DIR: assert property (two_terminal_mode_i == MODE_RUN_DIR && filt[1]
			|=> reverse_o)
		else $error("mode 1 direction wrong");
	AST_3WIRE_STOP: assert property (two_terminal_mode_i == MODE_3WIRE && !filt[1]
			|=> ##1 !run_o)
		else $error("three-wire stop not honoured");
	AST_3WIRE_IN3: assert property (two_terminal_mode_i == MODE_3WIRE
			&& codes[0] == FN_FAULT && filt[2] && !fault_o && codes[1] != FN_FAULT
			&& codes[2] != FN_FAULT && codes[3] != FN_FAULT && codes[4] != FN_FAULT
			&& codes[5] != FN_FAULT |=> !fault_o)
		else $error("input three function not ignored");
	AST_RAMP_FLOOR: assert property (f_up && !f_down && accel_time_i < RAMP_MIN_DS
			|=> ramp_time_o == RAMP_MIN_DS)
		else $error("ramp below floor");
	AST_AUTO_TOP: assert property (f_auto |=> speed_source_o == SRC_AUTO)
		else $error("auto not top priority");
	AST_JOG_SECOND: assert property (!f_auto && f_jog |=> speed_source_o == SRC_JOG)
		else $error("jog priority wrong");
	AST_RESTART: assert property ($rose(f_auto) |=> auto_restart_o ##1 !auto_restart_o)
		else $error("auto restart pulse wrong");
	AST_SCAN_GAP: assert property (scan_tick_reg |=> !scan_tick_reg [*8])
		else $error("scan ticks too close");

	COV_FAULT_RESET: cover property (fault_o ##[1:1000] !fault_o);
	COV_3WIRE_RUN: cover property (two_terminal_mode_i == MODE_3WIRE && run_o);
	COV_AUTO_PAUSE: cover property (auto_run_o && auto_pause_o);
	COV_STAGE: cover property (speed_source_o == SRC_STAGE && stage_sel_o == 4'hf);
endmodule

// ===== verification/dit_switch_model.sv
module dit_switch_model (
	input wire logic core_clk_i,
	input wire logic [7:0] level_i,
	input wire logic [7:0] glitch_i,
	output logic [7:0] terminals_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] settled_reg;
	logic [7:0] chg_reg;
	logic [2:0] cnt_reg;
	initial begin
		settled_reg = 8'h00;
		chg_reg = 8'h00;
		cnt_reg = 3'h0;
	end
	// Moved contacts chatter for six cycles, well inside one scan
	always @(posedge core_clk_i) begin
		if (level_i != settled_reg) begin
			chg_reg <= level_i ^ settled_reg;
			settled_reg <= level_i;
			cnt_reg <= 3'h6;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end
	end
	assign terminals_o = settled_reg ^ (cnt_reg[0] ? chg_reg : 8'h00) ^ glitch_i;
endmodule

// ===== verification/dit_decoder_tb_top.sv
`define CHK(a, e) begin \
	compares++; \
	if ((a) !== (e)) begin \
		fail_count++; \
		$display("unexpected at %0t: outputs %h want %h", $time, a, e); \
	end \
end

module dit_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dit_pkg::*;
	typedef struct packed {
		logic run, reverse_run, fault, coast, off, up, down;
		logic [3:0] stage;
		logic [2:0] src;
		logic arun, pause, pid, a1, fb;
		logic [15:0] ramp;
		logic [3:0] rcnt;
		logic [7:0] term;
	} dit_obs_t;
	localparam int unsigned UNIT = 2;
	localparam int SETTLE = 70;
	logic clk, rst, run, reverse_run, fault, coast, off, up, down, arun, pause, rstp, pid, a1, fb;
	logic [7:0] lvl, glt, term, filt, v, pv;
	logic [10:0] per;
	logic [1:0] mode, b;
	logic [3:0] fn [3:8];
	logic [3:0] rsrc, fsrc, rc, stage;
	logic [15:0] acc, dec, ramp, a, d;
	logic [31:0] rs;
	dit_src_t src;
	int fail_count, compares;
	dit_obs_t ex, mk, ob, e, m;
	dit_obs_t qe[$], qm[$];
	event chk_ev;
	logic [7:0] w3 [6] = '{8'h02, 8'h03, 8'h02, 8'h06, 8'h04, 8'h06};
	logic [5:0] r3 = 6'b001110;
	logic [12:0] ft [7] = '{{8'h01, 5'b11000}, {8'h05, 5'b10101}, {8'h01, 5'b10101},
		{8'h09, 5'b00000}, {8'h01, 5'b00000}, {8'h81, 5'b10011}, {8'h01, 5'b00000}};
	logic [7:0] pt [10] = '{8'h08, 8'h0c, 8'h1c, 8'h3c, 8'h7c, 8'h3c, 8'h1c, 8'h3c, 8'hbc, 8'h00};

	dit_switch_model sw (.core_clk_i(clk), .level_i(lvl), .glitch_i(glt), .terminals_o(term));
	dit_decoder #(.SCAN_UNIT_CYCLES(UNIT)) dut (.core_clk_i(clk), .rst_i(rst), .terminals_i(term),
		.input_scan_period_i(per), .two_terminal_mode_i(mode), .input3_function_i(fn[3]),
		.input4_function_i(fn[4]), .input5_function_i(fn[5]), .input6_function_i(fn[6]),
		.input7_function_i(fn[7]), .input8_function_i(fn[8]), .run_control_source_i(rsrc),
		.frequency_command_source_i(fsrc), .accel_time_i(acc), .decel_time_i(dec),
		.terminals_o(filt), .run_o(run), .reverse_o(reverse_run), .fault_o(fault), .coast_o(coast),
		.output_off_o(off), .speed_up_o(up), .speed_down_o(down), .ramp_time_o(ramp),
		.stage_sel_o(stage), .speed_source_o(src), .auto_run_o(arun), .auto_pause_o(pause),
		.auto_restart_o(rstp), .pid_enable_o(pid), .analog1_forced_o(a1),
		.fieldbus_enable_o(fb));

	assign ob = {run, reverse_run, fault, coast, off, up, down, stage, src, arun, pause, pid, a1, fb,
		ramp, rc, filt};

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] mx(input logic [15:0] x);
		return (x < RAMP_MIN_DS) ? RAMP_MIN_DS : x;
	endfunction
	task automatic final_report();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic st(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic put(input logic [7:0] x);
		@(posedge clk);
		lvl <= x;
		st(SETTLE);
		ex.term = x;
	endtask
	task automatic glitch(input logic [7:0] g, input int n);
		@(posedge clk);
		glt <= g;
		repeat (n) @(posedge clk);
		glt <= 8'h00;
		st(SETTLE);
	endtask
	task automatic note();
		qe.push_back(ex);
		qm.push_back(mk);
		->chk_ev;
	endtask
	task automatic cfg(input logic [3:0] p3, p4, p5, p6, p7, p8);
		@(posedge clk);
		fn <= '{p3, p4, p5, p6, p7, p8};
	endtask
	task automatic base(input string s);
		dit_obs_t k;
		$display("test %s finished", s);
		k = '0;
		k.src = SRC_CONFIG;
		k.ramp = ex.ramp;
		k.rcnt = ex.rcnt;
		ex = k;
		mk = '1;
		put(8'h00);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rc <= 4'h0;
		end else if (rstp === 1'b1) begin
			rc <= rc + 4'h1;
		end
	end
	initial forever begin
		@(chk_ev);
		while (qe.size() > 0) begin
			e = qe.pop_front();
			m = qm.pop_front();
			`CHK(ob & m, e & m)
		end
	end
	// Longest path is three slow-scan waits, one 9000-cycle wait and 77 settles
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		final_report();
	end

	initial begin
		rst = 1'b1;
		{lvl, glt, fsrc, acc, dec, mode} = '0;
		per = SCAN_SET_RST;
		fn = '{IN3_FN_RST, IN4_FN_RST, IN5_FN_RST, IN6_FN_RST, IN7_FN_RST, IN8_FN_RST};
		rsrc = RUN_SRC_TERMINAL;
		rs = 32'hb219_5600;
		fail_count = 0;
		compares = 0;
		ex = '0;
		ex.off = 1'b1;
		ex.ramp = RAMP_MIN_DS;
		ex.src = SRC_CONFIG;
		mk = '1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		note();
		base("reset");
		for (int md = 0; md < 2; md++) begin
			@(posedge clk);
			mode <= md[1:0];
			for (int i = 1; i < 5; i++) begin
				b = 2'(i % 4);
				put({6'h00, b});
				ex.run = (md == 0) ? ^b : b[0];
				ex.reverse_run = b[1];
				mk.reverse_run = ex.run;
				note();
			end
		end
		put(8'h01);
		@(posedge clk);
		rsrc <= 4'h2;
		st(3);
		ex.run = 1'b0;
		note();
		@(posedge clk);
		rsrc <= RUN_SRC_TERMINAL;
		mode <= 2'h3;
		st(3);
		note();
		base("two_wire");
		@(posedge clk);
		mode <= MODE_3WIRE;
		for (int i = 0; i < 6; i++) begin
			put(w3[i]);
			ex.run = r3[i];
			ex.reverse_run = w3[i][2];
			mk.reverse_run = r3[i];
			note();
		end
		base("three_wire");
		@(posedge clk);
		mode <= MODE_FWD_REV;
		glitch(8'h04, 15);
		note();
		// Reset input is released again right after use
		foreach (ft[i]) begin
			put(ft[i][12:5]);
			{mk.run, ex.run, ex.fault, ex.coast, ex.off} = ft[i][4:0];
			note();
		end
		base("fault");
		cfg(FN_FAULT, FN_RESET, FN_UP, FN_DOWN, FN_JOG, FN_COAST);
		for (int k = 0; k < 2; k++) begin
			rs = lfsr(rs);
			a = (k == 0) ? 16'h0096 : rs[15:0];
			d = rs[31:16];
			@(posedge clk);
			fsrc <= FREQ_SRC_UPDOWN;
			acc <= a;
			dec <= d;
			for (int j = 1; j < 4; j++) begin
				put(8'(j << 4));
				ex.up = (j == 1);
				ex.down = (j == 2);
				ex.ramp = mx(ex.down ? d : a);
				note();
			end
			@(posedge clk);
			fsrc <= 4'h2;
			put(8'h10);
			ex.up = 1'b0;
			note();
		end
		base("up_down");
		cfg(FN_STAGE0, FN_STAGE1, FN_STAGE2, FN_STAGE3, FN_JOG, FN_COAST);
		for (int c = 0; c < 16; c++) begin
			put(8'(c << 2));
			ex.stage = 4'(c);
			ex.src = (c == 0) ? SRC_CONFIG : SRC_STAGE;
			note();
		end
		base("stages");
		cfg(FN_ANALOG1, FN_STAGE0, FN_JOG, FN_AUTO, FN_PAUSE, FN_PID);
		pv = 8'h00;
		for (int i = 0; i < 18; i++) begin
			rs = lfsr(rs);
			v = (i < 10) ? pt[i] : (rs[7:0] & 8'hfc);
			put(v);
			ex.stage = {3'h0, v[3]};
			ex.a1 = v[2];
			ex.arun = v[5];
			ex.pause = v[5] & v[6];
			ex.pid = v[7];
			ex.rcnt += {3'h0, v[5] & ~pv[5]};
			ex.src = v[5] ? SRC_AUTO : v[4] ? SRC_JOG : v[2] ? SRC_ANALOG1 : v[3] ? SRC_STAGE
				: SRC_CONFIG;
			pv = v;
			note();
		end
		base("priority");
		cfg(FN_NONE, FN_NONE, FN_NONE, FN_NONE, FN_NONE, FN_FIELDBUS);
		put(8'hfc);
		ex.fb = 1'b1;
		note();
		cfg(FN_FIELDBUS, FN_NONE, FN_NONE, FN_NONE, FN_NONE, FN_NONE);
		put(8'h04);
		ex.fb = 1'b0;
		note();
		base("fieldbus");
		cfg(FN_NONE, FN_NONE, FN_NONE, FN_NONE, FN_NONE, FN_PID);
		per <= SCAN_SET_MAX;
		st(9000);
		@(posedge clk);
		lvl <= 8'h80;
		st(2500);
		note();
		st(6000);
		ex.pid = 1'b1;
		ex.term = 8'h80;
		note();
		@(posedge clk);
		per <= 11'h005;
		lvl <= 8'h00;
		st(9000);
		ex.pid = 1'b0;
		ex.term = 8'h00;
		glitch(8'h80, 15);
		note();
		put(8'h80);
		ex.pid = 1'b1;
		note();
		$display("test scan finished");
		st(5);
		final_report();
	end
endmodule
